// file: clsp_cfg.svh
// register offsets, reset values and timing constants of the steering position controller
`ifndef CLSP_CFG_SVH
`define CLSP_CFG_SVH
`define CLSP_OFF_CTRL 12'h000
`define CLSP_OFF_SHAPE 12'h004
`define CLSP_OFF_LIMIT 12'h008
`define CLSP_OFF_LOOP 12'h00c
`define CLSP_OFF_HOLD 12'h010
`define CLSP_OFF_INPUT 12'h014
`define CLSP_OFF_STATUS 12'h018
`define CLSP_OFF_FLOW 12'h01c
`define CLSP_PRINCIPLE_CLOSED 8'hff
`define CLSP_NUM_PROGRAMS 5
`define CLSP_RST_DEAD_BAND 16'sh0000
`define CLSP_RST_LINEARITY 16'sh0000
`define CLSP_RST_SATURATION 16'sh03e8
`define CLSP_RST_RIGHT_LIMIT 16'sh03e8
`define CLSP_RST_LEFT_LIMIT 16'shfc18
`define CLSP_RST_GAIN 16'sh0032
`define CLSP_RST_MAX_FLOW 16'sh03e8
`define CLSP_RST_STEADY_THRESHOLD 16'sh0032
`define CLSP_RST_NEUTRAL_DELAY_MS 16'h0bb8
`define CLSP_RST_BRIDGE_DELAY_MS 16'h7530
`define CLSP_BRIDGE_DELAY_OFF 16'h7530
`define CLSP_FULL_SCALE 16'sh03e8
`define CLSP_BEND_NUM 16'sh0014
`define CLSP_BEND_DEN 16'sh0028
`define CLSP_GAIN_DIV 16'sh0064
`define CLSP_TICK_NS 1000000
`define CLSP_CLK_NS 4
`endif

// file: clsp_pkg.sv
// types shared by the steering position controller files
package clsp_pkg;
	typedef enum logic [1:0] {
		clsp_idle_s = 2'b00,
		clsp_track_s = 2'b01,
		clsp_run_s = 2'b10
	} clsp_state_t;

	// one parameter program
	typedef struct packed {
		logic [7:0] control_principle_select;
		logic signed [15:0] center_dead_band;
		logic signed [15:0] curve_linearity;
		logic signed [15:0] saturation;
		logic signed [15:0] right_end_limit;
		logic signed [15:0] left_end_limit;
		logic signed [15:0] max_port_flow;
	} clsp_prog_t;

	// loop-wide settings
	typedef struct packed {
		logic signed [15:0] proportional_gain;
		logic signed [15:0] steady_threshold;
		logic [15:0] neutral_delay_ms;
		logic [15:0] bridge_delay_ms;
	} clsp_loop_t;
endpackage : clsp_pkg

// file: clsp_setpoint.sv
// angle-to-set-point transform: dead band, bend, saturation and end limits
`timescale 1ns/10ps
`include "clsp_cfg.svh"
module clsp_setpoint
	import clsp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire clsp_prog_t prog,
	input wire logic signed [15:0] angle,
	output logic signed [15:0] set_point
);
	logic signed [15:0] next_set_point;

	// straight-line interpolation between two points, not clipped at the ends
	function automatic logic signed [15:0] clsp_interp(input logic signed [31:0] x, input logic signed [31:0] x0,
		input logic signed [31:0] x1, input logic signed [31:0] y0, input logic signed [31:0] y1);
		logic signed [31:0] span;
		logic signed [31:0] r;
		span = (x1 > x0) ? (x1 - x0) : 32'sh1;
		r = y0 + ((y1 - y0) * (x - x0)) / span;
		return r[15:0];
	endfunction : clsp_interp

	// one quadrant curve; sign of the limit handles the opposite side
	function automatic logic signed [15:0] clsp_quadrant(input logic signed [31:0] mag, input clsp_prog_t p,
		input logic signed [31:0] lim);
		logic signed [31:0] db;
		logic signed [31:0] sat;
		logic signed [31:0] bx;
		logic signed [31:0] by;
		db = 32'(p.center_dead_band);
		sat = 32'(p.saturation);
		bx = (sat + db) / 2;
		by = (lim * (32'(`CLSP_BEND_NUM) - 32'(p.curve_linearity))) / 32'(`CLSP_BEND_DEN);
		if (mag <= db)
			return 16'sh0000;
		else if (mag >= sat)
			return lim[15:0];
		else if (mag <= bx)
			return clsp_interp(mag, db, bx, 32'sh0, by);
		else
			return clsp_interp(mag, bx, sat, by, lim);
	endfunction : clsp_quadrant

	// negative input uses the same shaping with the left limit
	always_comb
	begin
		if (angle >= 0)
			next_set_point = clsp_quadrant(32'(angle), prog, 32'(prog.right_end_limit));
		else
			next_set_point = clsp_quadrant(-32'(angle), prog, 32'(prog.left_end_limit));
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			set_point <= 16'sh0000;
		else
			set_point <= next_set_point;
	end
endmodule : clsp_setpoint

// file: clsp_ms_timer.sv
// millisecond hold timer: counts while a condition holds, reports expiry
`timescale 1ns/10ps
`include "clsp_cfg.svh"
module clsp_ms_timer #(
	parameter int TICK_CYCLES = `CLSP_TICK_NS / `CLSP_CLK_NS
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic hold,
	input wire logic [15:0] delay_ms,
	output logic expired
);
	logic [31:0] cyc;
	logic [15:0] ms;
	logic [31:0] next_cyc;
	logic [15:0] next_ms;
	logic next_expired;

	// any break in the condition restarts the whole delay
	always_comb
	begin
		next_cyc = cyc;
		next_ms = ms;
		next_expired = expired;
		if (!hold)
		begin
			next_cyc = 32'h0;
			next_ms = 16'h0;
			next_expired = 1'b0;
		end
		else if (ms >= delay_ms)
			next_expired = 1'b1;
		else if (cyc >= 32'(TICK_CYCLES - 1))
		begin
			next_cyc = 32'h0;
			next_ms = ms + 16'h1;
		end
		else
			next_cyc = cyc + 32'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cyc <= 32'h0;
			ms <= 16'h0;
			expired <= 1'b0;
		end
		else
		begin
			cyc <= next_cyc;
			ms <= next_ms;
			expired <= next_expired;
		end
	end
endmodule : clsp_ms_timer

// file: clsp_position_ctrl.sv
// closed-loop steering position controller with apb register file
//
// Operation
// - port flow command is held at zero while tracking
// - tracking ends when error reaches zero or changes sign
// - closed-loop control runs only when program principle value is 255
// - five parameter programs, index 0 to 4, selected as a whole
// - dead band around input centre, 0 to 250, output zero inside
// - linearity -10 to 10 bends the curve, zero is linear
// - bend point at (sat+db)/2, output limit*(20-linearity)/40
// - right and left end limits bound the set point; sign swap reverses
// - input beyond saturation drives set point to its end limit
// - negative inputs reuse saturation, dead band and linearity
// - gain 0 to 200 gives gain/100 flow tenths per error tenth
// - flow magnitude limited to max port flow, negative setting uses magnitude
// - spool neutral after flow stays within threshold for hold delay
// - spool reactivates once flow magnitude exceeds threshold again
// - bridge disabled after off-delay of zero flow request, else enabled
// - non-zero flow request re-enables the bridge at once
// - off-delay of 30000 ms disables the bridge-off function
`timescale 1ns/10ps
`include "clsp_cfg.svh"
module clsp_position_ctrl
	import clsp_pkg::*;
#(
	parameter int NUM_PROGRAMS = `CLSP_NUM_PROGRAMS,
	parameter int TICK_CYCLES = `CLSP_TICK_NS / `CLSP_CLK_NS
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [15:0] device_angle,
	input wire logic signed [15:0] actuator_position,
	output logic signed [15:0] port_flow,
	output logic spool_active,
	output logic bridge_enable
);
	clsp_prog_t progs [NUM_PROGRAMS];
	clsp_prog_t next_progs [NUM_PROGRAMS];
	clsp_loop_t loop_cfg;
	clsp_loop_t next_loop_cfg;
	logic [2:0] prog_index;
	logic [2:0] next_prog_index;
	logic [2:0] edit_index;
	logic [2:0] next_edit_index;
	logic loop_enable;
	logic next_loop_enable;
	clsp_state_t state;
	clsp_state_t next_state;
	logic signed [15:0] next_port_flow;
	logic next_spool_active;
	logic signed [15:0] prev_error;
	logic signed [15:0] next_prev_error;
	logic signed [15:0] set_point;
	logic signed [15:0] error;
	logic signed [15:0] flow_raw;
	logic neutral_expired;
	logic bridge_expired;
	logic [31:0] next_prdata;
	logic next_pslverr;
	clsp_prog_t active_prog;
	logic apb_wr;

	// magnitude of a signed value, saturated to 16 bits
	function automatic logic signed [15:0] clsp_abs(input logic signed [31:0] v);
		logic signed [31:0] m;
		m = (v < 0) ? -v : v;
		return (m > 32'sh7fff) ? 16'sh7fff : m[15:0];
	endfunction : clsp_abs

	// clamp a signed value to +/- a limit
	function automatic logic signed [15:0] clsp_clamp(input logic signed [31:0] v, input logic signed [15:0] lim);
		if (v > 32'(lim))
			return lim;
		else if (v < -32'(lim))
			return -lim;
		else
			return v[15:0];
	endfunction : clsp_clamp

	assign apb_wr = psel && penable && pwrite;
	assign pready = 1'b1; // zero wait states
	assign active_prog = progs[prog_index];

	clsp_setpoint u_setpoint (
		.pclk(pclk),
		.presetn(presetn),
		.prog(active_prog),
		.angle(device_angle),
		.set_point(set_point)
	);

	// error and proportional flow, each saturated to 16 bits; port-flow limit is applied in the run state
	always_comb
	begin
		error = clsp_clamp(32'(set_point) - 32'(actuator_position), 16'sh7fff);
		flow_raw = clsp_clamp((32'(error) * 32'(loop_cfg.proportional_gain)) / 32'(`CLSP_GAIN_DIV),
			16'sh7fff);
	end

	// steady-state neutral timer
	clsp_ms_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_neutral_timer (
		.pclk(pclk),
		.presetn(presetn),
		.hold(clsp_abs(32'(port_flow)) <= loop_cfg.steady_threshold),
		.delay_ms(loop_cfg.neutral_delay_ms),
		.expired(neutral_expired)
	);

	// zero-request bridge timer
	clsp_ms_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_bridge_timer (
		.pclk(pclk),
		.presetn(presetn),
		.hold(port_flow == 16'sh0000),
		.delay_ms(loop_cfg.bridge_delay_ms),
		.expired(bridge_expired)
	);

	// tracking and run state machine with flow shaping
	always_comb
	begin
		next_state = state;
		next_prev_error = error;
		next_port_flow = 16'sh0000;
		next_spool_active = spool_active;
		unique case (state)
			clsp_idle_s:
			begin
				next_spool_active = 1'b0;
				if (loop_enable && active_prog.control_principle_select == `CLSP_PRINCIPLE_CLOSED)
					next_state = clsp_track_s;
			end
			clsp_track_s:
			begin
				next_port_flow = 16'sh0000;
				next_spool_active = 1'b0;
				if (!loop_enable || active_prog.control_principle_select != `CLSP_PRINCIPLE_CLOSED)
					next_state = clsp_idle_s;
				else if (error == 16'sh0000 || (prev_error[15] != error[15] && prev_error != 16'sh0000))
					next_state = clsp_run_s;
			end
			clsp_run_s:
			begin
				next_port_flow = clsp_clamp(32'(flow_raw), clsp_abs(32'(active_prog.max_port_flow)));
				if (clsp_abs(32'(next_port_flow)) > loop_cfg.steady_threshold)
					next_spool_active = 1'b1;
				else if (neutral_expired)
					next_spool_active = 1'b0;
				if (!loop_enable || active_prog.control_principle_select != `CLSP_PRINCIPLE_CLOSED)
				begin
					next_state = clsp_idle_s;
					next_port_flow = 16'sh0000;
				end
			end
			default:
				next_state = clsp_idle_s;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= clsp_idle_s;
			prev_error <= 16'sh0000;
			port_flow <= 16'sh0000;
			spool_active <= 1'b0;
		end
		else
		begin
			state <= next_state;
			prev_error <= next_prev_error;
			port_flow <= next_port_flow;
			spool_active <= next_spool_active;
		end
	end

	// bridge stays on unless zero flow held for the off-delay; the max delay means never off
	assign bridge_enable = (port_flow != 16'sh0000) ||
		(loop_cfg.bridge_delay_ms >= `CLSP_BRIDGE_DELAY_OFF) || !bridge_expired;

	// register writes; edits go to the program chosen by the edit index
	always_comb
	begin
		next_progs = progs;
		next_loop_cfg = loop_cfg;
		next_prog_index = prog_index;
		next_edit_index = edit_index;
		next_loop_enable = loop_enable;
		if (apb_wr)
		begin
			unique case (paddr)
				`CLSP_OFF_CTRL:
				begin
					next_loop_enable = pwdata[0];
					if (pwdata[6:4] < 3'(NUM_PROGRAMS))
						next_prog_index = pwdata[6:4];
					if (pwdata[10:8] < 3'(NUM_PROGRAMS))
						next_edit_index = pwdata[10:8];
					next_progs[next_edit_index].control_principle_select = pwdata[23:16];
				end
				`CLSP_OFF_SHAPE:
				begin
					next_progs[edit_index].center_dead_band = pwdata[15:0];
					next_progs[edit_index].curve_linearity = pwdata[31:16];
				end
				`CLSP_OFF_LIMIT:
				begin
					next_progs[edit_index].right_end_limit = pwdata[15:0];
					next_progs[edit_index].left_end_limit = pwdata[31:16];
				end
				`CLSP_OFF_LOOP:
				begin
					next_progs[edit_index].saturation = pwdata[15:0];
					next_progs[edit_index].max_port_flow = pwdata[31:16];
				end
				`CLSP_OFF_HOLD:
				begin
					next_loop_cfg.neutral_delay_ms = pwdata[15:0];
					next_loop_cfg.bridge_delay_ms = pwdata[31:16];
				end
				`CLSP_OFF_INPUT:
				begin
					next_loop_cfg.proportional_gain = pwdata[15:0];
					next_loop_cfg.steady_threshold = pwdata[31:16];
				end
				default:
					next_loop_enable = loop_enable;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NUM_PROGRAMS; i++)
			begin
				progs[i].control_principle_select <= `CLSP_PRINCIPLE_CLOSED;
				progs[i].center_dead_band <= `CLSP_RST_DEAD_BAND;
				progs[i].curve_linearity <= `CLSP_RST_LINEARITY;
				progs[i].saturation <= `CLSP_RST_SATURATION;
				progs[i].right_end_limit <= `CLSP_RST_RIGHT_LIMIT;
				progs[i].left_end_limit <= `CLSP_RST_LEFT_LIMIT;
				progs[i].max_port_flow <= `CLSP_RST_MAX_FLOW;
			end
			loop_cfg.proportional_gain <= `CLSP_RST_GAIN;
			loop_cfg.steady_threshold <= `CLSP_RST_STEADY_THRESHOLD;
			loop_cfg.neutral_delay_ms <= `CLSP_RST_NEUTRAL_DELAY_MS;
			loop_cfg.bridge_delay_ms <= `CLSP_RST_BRIDGE_DELAY_MS;
			prog_index <= 3'h0;
			edit_index <= 3'h0;
			loop_enable <= 1'b0;
		end
		else
		begin
			progs <= next_progs;
			loop_cfg <= next_loop_cfg;
			prog_index <= next_prog_index;
			edit_index <= next_edit_index;
			loop_enable <= next_loop_enable;
		end
	end

	// read mux; unmapped addresses answer with pslverr and zero data
	always_comb
	begin
		next_prdata = 32'h0;
		next_pslverr = 1'b0;
		unique case (paddr)
			`CLSP_OFF_CTRL: next_prdata = {8'h0, progs[edit_index].control_principle_select, 5'h0, edit_index,
				1'b0, prog_index, 3'h0, loop_enable};
			`CLSP_OFF_SHAPE: next_prdata = {progs[edit_index].curve_linearity, progs[edit_index].center_dead_band};
			`CLSP_OFF_LIMIT: next_prdata = {progs[edit_index].left_end_limit, progs[edit_index].right_end_limit};
			`CLSP_OFF_LOOP: next_prdata = {progs[edit_index].max_port_flow, progs[edit_index].saturation};
			`CLSP_OFF_HOLD: next_prdata = {loop_cfg.bridge_delay_ms, loop_cfg.neutral_delay_ms};
			`CLSP_OFF_INPUT: next_prdata = {loop_cfg.steady_threshold, loop_cfg.proportional_gain};
			`CLSP_OFF_STATUS: next_prdata = {set_point, 11'h0, bridge_enable, spool_active, 1'b0, state};
			`CLSP_OFF_FLOW: next_prdata = {error, port_flow};
			default: next_pslverr = 1'b1;
		endcase
	end

	// read data is registered in the setup cycle so it stands in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata <= (psel && !penable && !pwrite) ? next_prdata : prdata;
			pslverr <= (psel && !penable) ? next_pslverr : 1'b0;
		end
	end
endmodule : clsp_position_ctrl

// file: clsp_position_ctrl_checker.sv
// port assertions for the steering position controller
`timescale 1ns/10ps
module clsp_position_ctrl_checker #(
	parameter int NUM_PROGRAMS = 5,
	parameter int TICK_CYCLES = 4
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic signed [15:0] device_angle,
	input wire logic signed [15:0] actuator_position,
	input wire logic signed [15:0] port_flow,
	input wire logic spool_active,
	input wire logic bridge_enable
);
	// the bench keeps the steady threshold at its reset value of 50
	logic small_flow;
	assign small_flow = (port_flow <= 16'sh0032) && (port_flow >= -16'sh0032);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_flow_range: assert property (port_flow <= 16'sh03e8 && port_flow >= -16'sh03e8)
		else $error("flow command beyond full scale");
	a_bridge_on_flow: assert property (port_flow != 16'sh0000 |-> bridge_enable)
		else $error("bridge off while flow is requested");
	a_bridge_fall: assert property ($fell(bridge_enable) |-> $past(port_flow) == 16'sh0000)
		else $error("bridge dropped after a nonzero request");
	a_spool_wake: assert property (!small_flow |=> spool_active)
		else $error("spool not reactivated on large flow");
	a_spool_fall: assert property ($fell(spool_active) |-> $past(small_flow, 2))
		else $error("spool neutral while flow was large");
	a_pready_high: assert property (pready)
		else $error("wait state inserted");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access phase");
	a_read_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved without a setup cycle");
endmodule : clsp_position_ctrl_checker

bind clsp_position_ctrl clsp_position_ctrl_checker #(.NUM_PROGRAMS(NUM_PROGRAMS), .TICK_CYCLES(TICK_CYCLES)) i_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.device_angle, .actuator_position, .port_flow, .spool_active, .bridge_enable);

// file: clsp_partner.sv
// behavioural steering device sensor and cylinder actuator
`timescale 1ns/10ps
module clsp_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic signed [15:0] angle_cmd,
	input wire logic signed [15:0] pos_cmd,
	input wire logic follow,
	input wire logic signed [15:0] port_flow,
	input wire logic spool_active,
	input wire logic bridge_enable,
	output logic signed [15:0] device_angle,
	output logic signed [15:0] actuator_position
);
	logic signed [15:0] next_position;
	// cylinder creeps one unit a cycle; a neutral spool or dead bridge stops it
	always_comb
	begin
		next_position = actuator_position;
		if (!follow)
			next_position = pos_cmd;
		else if (spool_active && bridge_enable && port_flow != 16'sh0000)
			next_position = actuator_position + ((port_flow > 16'sh0000) ? 16'sh0001 : -16'sh0001);
	end
	// sensor samples the knob once a cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			device_angle <= 16'sh0000;
			actuator_position <= 16'sh0000;
		end
		else
		begin
			device_angle <= angle_cmd;
			actuator_position <= next_position;
		end
	end
endmodule : clsp_partner

// file: clsp_position_ctrl_tb_top.sv
// self-checking bench for the steering position controller
`timescale 1ns/10ps
`include "clsp_cfg.svh"
module clsp_position_ctrl_tb_top;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic follow = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] r;
	logic pready, pslverr, spool_active, bridge_enable, e;
	logic signed [15:0] device_angle, actuator_position, port_flow;
	logic signed [15:0] angle_cmd = 16'sh0000;
	logic signed [15:0] pos_cmd = 16'sh0000;
	int errors = 0;
	int total_checks = 0;
	// transform table: control word, shape, limits, angle, expected set point
	logic [31:0] tc [10] = '{32'h00ff0000, 32'h00ff0000, 32'h00ff0000, 32'h00ff0000, 32'h00ff0000,
		32'h00ff0000, 32'h00ff0000, 32'h00ff0000, 32'h00ff0110, 32'h00ff0100};
	logic [31:0] ts [10] = '{32'h0, 32'h0, 32'h0, 32'h000a0000, 32'hfff60000, 32'h00000064, 32'h0, 32'h0,
		32'h00000064, 32'h00000064};
	logic [31:0] tl [10] = '{32'hfc1803e8, 32'hfc1803e8, 32'hfc1803e8, 32'hfc1803e8, 32'hfc1803e8,
		32'hfc1803e8, 32'h03e8fc18, 32'hfc1803e8, 32'hfc1803e8, 32'hfc1803e8};
	logic signed [15:0] ta [10] = '{16'sh04b0, -16'sh04b0, 16'sh0190, 16'sh01f4, -16'sh01f4, -16'sh0050,
		16'sh04b0, 16'sh0032, 16'sh0032, 16'sh0032};
	logic signed [15:0] te [10] = '{16'sh03e8, -16'sh03e8, 16'sh0190, 16'sh00fa, -16'sh02ee, 16'sh0000,
		-16'sh03e8, 16'sh0032, 16'sh0000, 16'sh0032};

	always #2 pclk = ~pclk;

	// millisecond tick shortened to four cycles
	clsp_position_ctrl #(.TICK_CYCLES(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .device_angle, .actuator_position, .port_flow, .spool_active, .bridge_enable);
	clsp_partner i_far (.pclk, .presetn, .angle_cmd, .pos_cmd, .follow, .port_flow, .spool_active,
		.bridge_enable, .device_angle, .actuator_position);

	task chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x)
		begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// request is held until the edge where pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		chk(r, x);
	endtask : rd

	task finish_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	// the whole run needs about a thousand cycles
	initial
	begin
		cyc(5000);
		errors++;
		finish_test;
	end

	initial
	begin
		cyc(4);
		presetn <= 1'h1;
		rd(`CLSP_OFF_CTRL, 32'h00ff0000);
		rd(`CLSP_OFF_HOLD, 32'h75300bb8);
		rd(`CLSP_OFF_INPUT, 32'h00320032);
		rd(`CLSP_OFF_LOOP, 32'h03e803e8);
		rd(`CLSP_OFF_LIMIT, 32'hfc1803e8);
		rd(12'h020, 32'h0);
		chk({31'h0, e}, 32'h1);
		for (int i = 0; i < 10; i++)
		begin
			apb(1'h1, `CLSP_OFF_CTRL, tc[i]);
			apb(1'h1, `CLSP_OFF_SHAPE, ts[i]);
			apb(1'h1, `CLSP_OFF_LIMIT, tl[i]);
			angle_cmd <= ta[i];
			cyc(4);
			apb(1'h0, `CLSP_OFF_STATUS, 32'h0);
			chk({16'h0, r[31:16]}, {16'h0, te[i]});
		end
		// loop start with the knob away from the cylinder
		pos_cmd <= 16'sh0064;
		angle_cmd <= 16'sh0000;
		apb(1'h1, `CLSP_OFF_CTRL, 32'h00000001);
		cyc(6);
		apb(1'h0, `CLSP_OFF_STATUS, 32'h0);
		chk({30'h0, r[1:0]}, 32'h0);
		apb(1'h1, `CLSP_OFF_CTRL, 32'h00ff0001);
		cyc(6);
		apb(1'h0, `CLSP_OFF_STATUS, 32'h0);
		chk({30'h0, r[1:0]}, 32'h1);
		chk({16'h0, port_flow}, 32'h0);
		angle_cmd <= 16'sh0064;
		cyc(6);
		apb(1'h0, `CLSP_OFF_STATUS, 32'h0);
		chk({30'h0, r[1:0]}, 32'h2);
		angle_cmd <= 16'sh012c;
		cyc(6);
		chk({16'h0, port_flow}, 32'h00000064);
		rd(`CLSP_OFF_FLOW, 32'h00c80064);
		chk({31'h0, spool_active}, 32'h1);
		apb(1'h1, `CLSP_OFF_LOOP, 32'hffc403e8);
		angle_cmd <= -16'sh00c8;
		cyc(6);
		chk({16'h0, port_flow}, 32'h0000ffc4);
		apb(1'h1, `CLSP_OFF_LOOP, 32'h03e803e8);
		apb(1'h1, `CLSP_OFF_HOLD, 32'h75300002);
		angle_cmd <= 16'sh00b4;
		cyc(3);
		chk({31'h0, spool_active}, 32'h1);
		cyc(20);
		chk({31'h0, spool_active}, 32'h0);
		angle_cmd <= 16'sh012c;
		cyc(6);
		chk({31'h0, spool_active}, 32'h1);
		angle_cmd <= 16'sh0064;
		cyc(40);
		chk({31'h0, bridge_enable}, 32'h1);
		// short off delay as used without a wheel angle sensor: 50 ms
		apb(1'h1, `CLSP_OFF_HOLD, 32'h00320002);
		cyc(30);
		chk({31'h0, bridge_enable}, 32'h1);
		cyc(180);
		chk({31'h0, bridge_enable}, 32'h0);
		// the longest delay keeps the bridge on even with the timer run out
		apb(1'h1, `CLSP_OFF_HOLD, 32'h75300002);
		cyc(2);
		chk({31'h0, bridge_enable}, 32'h1);
		apb(1'h1, `CLSP_OFF_HOLD, 32'h00320002);
		cyc(2);
		chk({31'h0, bridge_enable}, 32'h0);
		angle_cmd <= 16'sh012c;
		cyc(4);
		chk({31'h0, bridge_enable}, 32'h1);
		// let the cylinder chase the set point until the spool parks
		follow <= 1'h1;
		cyc(400);
		chk({31'h0, port_flow >= 16'sh0000 && port_flow <= 16'sh0032}, 32'h1);
		chk({31'h0, spool_active}, 32'h0);
		finish_test;
	end
endmodule : clsp_position_ctrl_tb_top
